// >>> sxb_bridge.v
// Added by the designer: the APB register port.
`default_nettype none
`include "sxb_consts.vh"
module sxb_bridge #(
	parameter TOUT_CYC = `SXB_TOUT_MS * `SXB_CLK_KHZ
) (
	input wire pclk,
	input wire presetn,
	input wire [11:0] paddr,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire smb_clk_in,
	output wire smb_clk_out,
	output wire smb_clk_oe,
	input wire smb_data_in,
	output wire smb_data_out,
	output wire smb_data_oe,
	input wire lpc_req,
	output wire lpc_gnt,
	input wire lpc_cyc,
	input wire [15:0] lpc_addr,
	input wire lpc_write,
	input wire [7:0] lpc_wdata,
	output wire [7:0] lpc_rdata,
	output wire lpc_done,
	output wire lpc_abort,
	output wire chip_sel_zero_n,
	output wire chip_sel_one_hi,
	output wire chip_sel_two_n,
	output wire chip_sel_three_n,
	output wire ext_read_strobe_n,
	output wire ext_write_strobe_n,
	output wire [3:0] ext_addr_bus,
	input wire [7:0] ext_data_in,
	output wire [7:0] ext_data_out,
	output wire ext_data_oe
);
	localparam [8:0] S_IDLE = 9'h001;
	localparam [8:0] S_ADDR = 9'h002;
	localparam [8:0] S_ACK = 9'h004;
	localparam [8:0] S_CMD = 9'h008;
	localparam [8:0] S_WDAT = 9'h010;
	localparam [8:0] S_WEND = 9'h020;
	localparam [8:0] S_STR = 9'h040;
	localparam [8:0] S_TX = 9'h080;
	localparam [8:0] S_MACK = 9'h100;
	localparam [1:0] OWN_LPC = 2'b01;
	localparam [1:0] OWN_SMB = 2'b10;
	localparam [3:0] XB_END = `SXB_XB_SETUP + `SXB_XB_STROBE + `SXB_XB_HOLD - 4'd1;
	localparam [3:0] XB_STB_END = `SXB_XB_SETUP + `SXB_XB_STROBE;
	localparam [31:0] TOUT_LAST_W = TOUT_CYC - 1;
	localparam [19:0] TOUT_LAST = TOUT_LAST_W[19:0];

	// ============================================================
	// Pin synchronisers and serial line events
	wire scl_s;
	wire sda_s;
	wire [7:0] xd_s;
	reg scl_d_ff;
	reg sda_d_ff;
	wire scl_rise;
	wire scl_fall;
	wire start_ev;
	wire stop_ev;

	sxb_sync #(.W(10)) u_sync (
		.clk(pclk),
		.rst_n(presetn),
		.d({ext_data_in, smb_clk_in, smb_data_in}),
		.q({xd_s, scl_s, sda_s})
	);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scl_d_ff <= 1'b1;
			sda_d_ff <= 1'b1;
		end else begin
			scl_d_ff <= scl_s;
			sda_d_ff <= sda_s;
		end
	end

	assign scl_rise = scl_s & ~scl_d_ff;
	assign scl_fall = ~scl_s & scl_d_ff;
	assign start_ev = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
	assign stop_ev = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

	// ============================================================
	// Configuration registers
	reg [31:0] base_hi_ff;
	reg [31:0] base_lo_ff;
	reg [7:0] mode_ff;
	reg [7:0] osc_ff;
	reg [6:0] saddr_ff;
	wire [9:0] idx;
	wire wr_en;
	wire wp;
	wire prot_idx;
	reg mapped;

	assign idx = paddr[11:2];
	assign wr_en = psel & penable & pwrite;
	assign wp = base_lo_ff[8 + `SXB_BIT_WP];
	assign prot_idx = (idx >= `SXB_IDX_CS1_A) && (idx <= `SXB_IDX_CS3_B);
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			base_hi_ff <= {4{`SXB_RST_BASE}};
			base_lo_ff <= {4{`SXB_RST_BASE}};
			mode_ff <= `SXB_RST_MODE;
			osc_ff <= `SXB_RST_OSC;
			saddr_ff <= `SXB_RST_SADDR;
		end else if (wr_en && !(wp && prot_idx)) begin
			case (idx)
				`SXB_IDX_CS0_A: base_hi_ff[7:0] <= pwdata[7:0];
				`SXB_IDX_CS0_B: base_lo_ff[7:0] <= pwdata[7:0];
				`SXB_IDX_CS1_A: base_hi_ff[15:8] <= pwdata[7:0];
				`SXB_IDX_CS1_B: base_lo_ff[15:8] <= {pwdata[7:2], pwdata[1] | wp, pwdata[0]};
				`SXB_IDX_CS2_A: base_hi_ff[23:16] <= pwdata[7:0];
				`SXB_IDX_CS2_B: base_lo_ff[23:16] <= pwdata[7:0];
				`SXB_IDX_CS3_A: base_hi_ff[31:24] <= pwdata[7:0];
				`SXB_IDX_CS3_B: base_lo_ff[31:24] <= pwdata[7:0];
				`SXB_IDX_SADDR: saddr_ff <= pwdata[6:0];
				`SXB_IDX_MODE: mode_ff <= pwdata[7:0];
				`SXB_IDX_OSC: osc_ff <= pwdata[7:0];
				default: mode_ff <= mode_ff;
			endcase
		end
	end

	// ============================================================
	// Arbitration between the host and the SMBus
	reg [1:0] owner_ff;
	reg arb_req_ff;
	reg arb_ovr_ff;
	wire smb_want;

	assign smb_want = arb_req_ff | arb_ovr_ff;
	assign lpc_gnt = owner_ff[0];

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			owner_ff <= 2'b00;
		end else if (arb_ovr_ff) begin
			owner_ff <= OWN_SMB;
		end else begin
			case (owner_ff)
				OWN_LPC: owner_ff <= lpc_req ? OWN_LPC : 2'b00;
				OWN_SMB: owner_ff <= smb_want ? OWN_SMB : 2'b00;
				default: owner_ff <= lpc_req ? OWN_LPC : (smb_want ? OWN_SMB : 2'b00);
			endcase
		end
	end

	// ============================================================
	// SMBus slave
	reg [8:0] st_ff;
	reg [8:0] ret_ff;
	reg [3:0] cnt_ff;
	reg [6:0] sh_ff;
	reg [7:0] cmd_ff;
	reg [7:0] wdat_ff;
	reg [7:0] tx_ff;
	reg rd2_ff;
	reg ack_on_ff;
	reg sda_oe_ff;
	reg scl_oe_ff;
	reg [3:0] str_cnt_ff;
	reg [19:0] tout_ff;
	reg smb_wr_go_ff;
	reg smb_rd_go_ff;
	reg smb_rdy_ff;
	reg [7:0] smb_rdata_ff;
	wire [7:0] byte_in;
	wire tout_hit;

	assign byte_in = {sh_ff, sda_s};
	assign tout_hit = (tout_ff == TOUT_LAST);
	assign smb_clk_out = 1'b0;
	assign smb_data_out = 1'b0;
	assign smb_clk_oe = scl_oe_ff;
	assign smb_data_oe = sda_oe_ff;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tout_ff <= 20'h00000;
		end else if (scl_s || tout_hit) begin
			tout_ff <= 20'h00000;
		end else begin
			tout_ff <= tout_ff + 20'h00001;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= S_IDLE;
			ret_ff <= S_IDLE;
			cnt_ff <= 4'h0;
			sh_ff <= 7'h00;
			cmd_ff <= 8'h00;
			wdat_ff <= 8'h00;
			tx_ff <= 8'h00;
			rd2_ff <= 1'b0;
			ack_on_ff <= 1'b0;
			sda_oe_ff <= 1'b0;
			scl_oe_ff <= 1'b0;
			str_cnt_ff <= 4'h0;
			smb_wr_go_ff <= 1'b0;
			smb_rd_go_ff <= 1'b0;
			arb_req_ff <= 1'b0;
			arb_ovr_ff <= 1'b0;
		end else begin
			smb_wr_go_ff <= 1'b0;
			smb_rd_go_ff <= 1'b0;
			if (tout_hit || stop_ev) begin
				// Timeout, early stop and start-stop all land here.
				if (stop_ev && st_ff == S_WEND) begin
					if (cmd_ff == `SXB_CMD_ARB) begin
						arb_req_ff <= wdat_ff[`SXB_ARB_REQ];
						arb_ovr_ff <= wdat_ff[`SXB_ARB_OVR];
					end else begin
						smb_wr_go_ff <= 1'b1;
					end
				end
				st_ff <= S_IDLE;
				sda_oe_ff <= 1'b0;
				scl_oe_ff <= 1'b0;
				ack_on_ff <= 1'b0;
			end else if (start_ev) begin
				cnt_ff <= 4'h0;
				sda_oe_ff <= 1'b0;
				ack_on_ff <= 1'b0;
				if (st_ff == S_IDLE) begin
					st_ff <= S_ADDR;
					rd2_ff <= 1'b0;
				end else if (st_ff == S_WDAT && cnt_ff == 4'h1) begin
					// A repeated start always follows one rising clock that was counted as a data bit.
					st_ff <= S_ADDR;
					rd2_ff <= 1'b1;
				end else begin
					st_ff <= S_IDLE;
				end
			end else begin
				case (st_ff)
					S_ADDR, S_CMD, S_WDAT: begin
						if (scl_rise) begin
							sh_ff <= byte_in[6:0];
							cnt_ff <= cnt_ff + 4'h1;
							if (cnt_ff == 4'h7) begin
								cnt_ff <= 4'h0;
								st_ff <= S_ACK;
								if (st_ff == S_ADDR) begin
									ret_ff <= rd2_ff ? S_STR : S_CMD;
									if (byte_in[7:1] != saddr_ff || byte_in[0] != rd2_ff)
										st_ff <= S_IDLE;
									else if (rd2_ff)
										smb_rd_go_ff <= 1'b1;
								end else if (st_ff == S_CMD) begin
									cmd_ff <= byte_in;
									ret_ff <= S_WDAT;
								end else begin
									wdat_ff <= byte_in;
									ret_ff <= S_WEND;
								end
							end
						end
					end
					S_ACK: begin
						if (scl_fall) begin
							if (!ack_on_ff) begin
								sda_oe_ff <= 1'b1;
								ack_on_ff <= 1'b1;
							end else begin
								sda_oe_ff <= 1'b0;
								ack_on_ff <= 1'b0;
								st_ff <= ret_ff;
								if (ret_ff == S_STR) begin
									scl_oe_ff <= 1'b1;
									str_cnt_ff <= 4'h0;
								end
							end
						end
					end
					S_WEND: begin
						// A stop also begins with a rising clock, so only a falling clock marks a second byte.
						if (scl_fall)
							st_ff <= S_IDLE;
					end
					S_STR: begin
						str_cnt_ff <= str_cnt_ff + 4'h1;
						if (smb_rdy_ff || str_cnt_ff == `SXB_STRETCH_MAX - 4'd1) begin
							scl_oe_ff <= 1'b0;
							tx_ff <= smb_rdy_ff ? smb_rdata_ff : 8'h00;
							sda_oe_ff <= ~(smb_rdy_ff & smb_rdata_ff[7]);
							cnt_ff <= 4'h0;
							st_ff <= S_TX;
						end
					end
					S_TX: begin
						if (scl_fall) begin
							if (cnt_ff == 4'h7) begin
								sda_oe_ff <= 1'b0;
								st_ff <= S_MACK;
							end else begin
								tx_ff <= {tx_ff[6:0], 1'b0};
								sda_oe_ff <= ~tx_ff[6];
								cnt_ff <= cnt_ff + 4'h1;
							end
						end
					end
					S_MACK: begin
						if (scl_rise)
							st_ff <= S_IDLE;
					end
					default: st_ff <= S_IDLE;
				endcase
			end
		end
	end

	// ============================================================
	// External bus cycle engine
	wire [3:0] lpc_hit;
	wire [3:0] smb_hit;
	reg xb_busy_ff;
	reg xb_src_ff;
	reg xb_wr_ff;
	reg [3:0] xb_cnt_ff;
	reg [3:0] xb_cs_ff;
	reg [3:0] xb_addr_ff;
	reg [7:0] xb_dout_ff;
	reg [7:0] lpc_rdata_ff;
	reg lpc_done_ff;
	reg lpc_abort_ff;
	wire stb_on;
	wire lpc_go;
	wire smb_go;

	sxb_xdec u_xdec (
		.addr(lpc_addr),
		.cmd(cmd_ff),
		.base_hi(base_hi_ff),
		.base_lo(base_lo_ff),
		.mode2(mode_ff[`SXB_BIT_MODE]),
		.qual16(osc_ff[`SXB_BIT_Q16]),
		.lpc_hit(lpc_hit),
		.smb_hit(smb_hit)
	);

	assign stb_on = xb_busy_ff && xb_cnt_ff >= `SXB_XB_SETUP && xb_cnt_ff < XB_STB_END;
	assign lpc_go = lpc_cyc & (owner_ff == OWN_LPC) & ~xb_busy_ff & (|lpc_hit);
	assign smb_go = (smb_wr_go_ff | smb_rd_go_ff) & (owner_ff == OWN_SMB) & ~xb_busy_ff & (|smb_hit);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			xb_busy_ff <= 1'b0;
			xb_src_ff <= 1'b0;
			xb_wr_ff <= 1'b0;
			xb_cnt_ff <= 4'h0;
			xb_cs_ff <= 4'h0;
			xb_addr_ff <= 4'h0;
			xb_dout_ff <= 8'h00;
			lpc_rdata_ff <= 8'h00;
			lpc_done_ff <= 1'b0;
			lpc_abort_ff <= 1'b0;
			smb_rdy_ff <= 1'b0;
			smb_rdata_ff <= 8'h00;
		end else begin
			lpc_done_ff <= 1'b0;
			lpc_abort_ff <= 1'b0;
			if (smb_rd_go_ff) begin
				smb_rdy_ff <= ~smb_go;
				if (cmd_ff == `SXB_CMD_ARB)
					smb_rdata_ff <= {4'h0, arb_ovr_ff, 1'b0, owner_ff == OWN_SMB, arb_req_ff};
				else
					smb_rdata_ff <= 8'h00;
			end
			if (lpc_cyc && !lpc_go && !xb_busy_ff) begin
				lpc_done_ff <= 1'b1;
				lpc_rdata_ff <= 8'hff;
			end
			if (lpc_go || smb_go) begin
				xb_busy_ff <= 1'b1;
				xb_src_ff <= smb_go;
				xb_wr_ff <= lpc_go ? lpc_write : smb_wr_go_ff;
				xb_cnt_ff <= 4'h0;
				xb_cs_ff <= lpc_go ? lpc_hit : smb_hit;
				xb_addr_ff <= lpc_go ? lpc_addr[3:0] : cmd_ff[3:0];
				xb_dout_ff <= lpc_go ? lpc_wdata : wdat_ff;
			end else if (xb_busy_ff && !xb_src_ff && arb_ovr_ff) begin
				xb_busy_ff <= 1'b0;
				xb_cs_ff <= 4'h0;
				lpc_abort_ff <= 1'b1;
			end else if (xb_busy_ff) begin
				xb_cnt_ff <= xb_cnt_ff + 4'h1;
				if (xb_cnt_ff == XB_STB_END - 4'd1 && !xb_wr_ff) begin
					if (xb_src_ff) begin
						smb_rdata_ff <= xd_s;
						smb_rdy_ff <= 1'b1;
					end else begin
						lpc_rdata_ff <= xd_s;
					end
				end
				if (xb_cnt_ff == XB_END) begin
					xb_busy_ff <= 1'b0;
					xb_cs_ff <= 4'h0;
					lpc_done_ff <= ~xb_src_ff;
				end
			end
		end
	end

	assign chip_sel_zero_n = ~xb_cs_ff[0];
	assign chip_sel_one_hi = xb_cs_ff[1];
	assign chip_sel_two_n = ~xb_cs_ff[2];
	assign chip_sel_three_n = ~xb_cs_ff[3];
	assign ext_read_strobe_n = ~(stb_on & ~xb_wr_ff);
	assign ext_write_strobe_n = ~(stb_on & xb_wr_ff);
	assign ext_addr_bus = xb_addr_ff;
	assign ext_data_out = xb_dout_ff;
	assign ext_data_oe = xb_busy_ff & xb_wr_ff;
	assign lpc_rdata = lpc_rdata_ff;
	assign lpc_done = lpc_done_ff;
	assign lpc_abort = lpc_abort_ff;

	// ============================================================
	// Register read path
	always @* begin
		mapped = 1'b1;
		prdata = 32'h00000000;
		case (idx)
			`SXB_IDX_CS0_A: prdata[7:0] = base_hi_ff[7:0];
			`SXB_IDX_CS0_B: prdata[7:0] = base_lo_ff[7:0];
			`SXB_IDX_CS1_A: prdata[7:0] = base_hi_ff[15:8];
			`SXB_IDX_CS1_B: prdata[7:0] = base_lo_ff[15:8];
			`SXB_IDX_CS2_A: prdata[7:0] = base_hi_ff[23:16];
			`SXB_IDX_CS2_B: prdata[7:0] = base_lo_ff[23:16];
			`SXB_IDX_CS3_A: prdata[7:0] = base_hi_ff[31:24];
			`SXB_IDX_CS3_B: prdata[7:0] = base_lo_ff[31:24];
			`SXB_IDX_SADDR: prdata[6:0] = saddr_ff;
			`SXB_IDX_STATUS: prdata[7:0] = {3'b000, st_ff == S_IDLE, xb_busy_ff, arb_ovr_ff, owner_ff};
			`SXB_IDX_MODE: prdata[7:0] = mode_ff;
			`SXB_IDX_OSC: prdata[7:0] = osc_ff;
			default: mapped = 1'b0;
		endcase
	end
endmodule // sxb_bridge
`default_nettype wire

// >>> sxb_consts.vh
`ifndef SXB_CONSTS_VH
`define SXB_CONSTS_VH

// ============================================================
// Register indexes (byte address is four times the index)
`define SXB_IDX_CS0_A 10'h060
`define SXB_IDX_CS0_B 10'h061
`define SXB_IDX_CS1_A 10'h062
`define SXB_IDX_CS1_B 10'h063
`define SXB_IDX_CS2_A 10'h064
`define SXB_IDX_CS2_B 10'h065
`define SXB_IDX_CS3_A 10'h066
`define SXB_IDX_CS3_B 10'h067
`define SXB_IDX_SADDR 10'h068
`define SXB_IDX_STATUS 10'h069
`define SXB_IDX_MODE 10'h0f0
`define SXB_IDX_OSC 10'h024

// ============================================================
// Reset values and fields
`define SXB_RST_BASE 8'h00
`define SXB_RST_MODE 8'h00
`define SXB_RST_OSC 8'h00
`define SXB_RST_SADDR 7'h2c
`define SXB_BIT_DIS 0
`define SXB_BIT_WP 1
`define SXB_BIT_MODE 0
`define SXB_BIT_Q16 6

// ============================================================
// SMBus command codes and arbitration fields
`define SXB_CMD_ARB 8'h02
`define SXB_CMD_CS_BASE 4'h8
`define SXB_ARB_REQ 0
`define SXB_ARB_GNT 1
`define SXB_ARB_OVR 3

// ============================================================
// Timing
`define SXB_CLK_KHZ 25000
`define SXB_TOUT_MS 35
`define SXB_STRETCH_MAX 4'd10
`define SXB_XB_SETUP 4'd1
`define SXB_XB_STROBE 4'd4
`define SXB_XB_HOLD 4'd1
`endif

// >>> sxb_sync.v
`default_nettype none
module sxb_sync #(
	parameter W = 1
) (
	input wire clk,
	input wire rst_n,
	input wire [W-1:0] d,
	output wire [W-1:0] q
);
	reg [W-1:0] meta_ff;
	reg [W-1:0] sync_ff;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_ff <= {W{1'b0}};
			sync_ff <= {W{1'b0}};
		end else begin
			meta_ff <= d;
			sync_ff <= meta_ff;
		end
	end

	assign q = sync_ff;
endmodule // sxb_sync
`default_nettype wire

// >>> sxb_xdec.v
`default_nettype none
`include "sxb_consts.vh"
module sxb_xdec (
	input wire [15:0] addr,
	input wire [7:0] cmd,
	input wire [31:0] base_hi,
	input wire [31:0] base_lo,
	input wire mode2,
	input wire qual16,
	output wire [3:0] lpc_hit,
	output wire [3:0] smb_hit
);
	wire q_ok;
	wire [3:0] en;

	assign q_ok = ~qual16 | (addr[15:12] == 4'h0);
	assign en = {~base_lo[24], ~base_lo[16], ~base_lo[8], 1'b1};
	assign lpc_hit[0] = q_ok & (addr[11:0] == {base_hi[3:0], base_lo[7:0]});
	assign lpc_hit[1] = q_ok & en[1] & (addr[11:2] == {base_hi[11:8], base_lo[15:10]});

	genvar k;
	generate
		for (k = 0; k < 4; k = k + 1) begin : g_smb
			localparam [31:0] CODE_W = `SXB_CMD_CS_BASE + k;
			assign smb_hit[k] = en[k] & (cmd[7:4] == CODE_W[3:0]);
		end
		for (k = 2; k < 4; k = k + 1) begin : g_lpc
			wire m1;
			wire m2;
			assign m1 = addr[15:2] == {base_hi[8*k +: 8], base_lo[8*k+2 +: 6]};
			assign m2 = addr[15:4] == {base_hi[8*k +: 8], base_lo[8*k+4 +: 4]};
			assign lpc_hit[k] = q_ok & en[k] & (mode2 ? m2 : m1);
		end
	endgenerate
endmodule // sxb_xdec
`default_nettype wire

// >>> sxb_bridge_assertions.sv
`default_nettype none
// ============================================================
// Port checker for the bridge.
module sxb_bridge_chk (
	input wire pclk,
	input wire presetn,
	input wire smb_clk_oe,
	input wire lpc_req,
	input wire lpc_gnt,
	input wire lpc_done,
	input wire lpc_abort,
	input wire chip_sel_zero_n,
	input wire chip_sel_one_hi,
	input wire chip_sel_two_n,
	input wire chip_sel_three_n,
	input wire ext_read_strobe_n,
	input wire ext_write_strobe_n,
	input wire ext_data_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	wire [3:0] sel = {~chip_sel_three_n, ~chip_sel_two_n, chip_sel_one_hi, ~chip_sel_zero_n};
	logic [4:0] hold_ff;
	logic [4:0] nxt_hold;
	assign nxt_hold = smb_clk_oe ? hold_ff + 5'h01 : 5'h00;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			hold_ff <= 5'h00;
		else
			hold_ff <= nxt_hold;
	end
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence strobe_win(s);
		!s [*4] ##1 s;
	endsequence
	AST_STRETCH_MAX: assert property (hold_ff <= 5'h0a)
		else $error("serial clock held low too long");
	AST_ONE_SELECT: assert property ($onehot0(sel))
		else $error("several chip selects active");
	AST_STROBE_SELECT: assert property (!(ext_read_strobe_n && ext_write_strobe_n) |-> $onehot(sel))
		else $error("strobe without one select");
	AST_READ_WIDTH: assert property ($fell(ext_read_strobe_n) |-> strobe_win(ext_read_strobe_n))
		else $error("read strobe width wrong");
	AST_WRITE_WIDTH: assert property ($fell(ext_write_strobe_n) |-> ext_data_oe throughout strobe_win(ext_write_strobe_n))
		else $error("write strobe width or drive wrong");
	AST_READ_NO_DRIVE: assert property (!ext_read_strobe_n |-> !ext_data_oe)
		else $error("data driven during read");
	AST_SELECT_STEADY: assert property ($fell(ext_read_strobe_n && ext_write_strobe_n) |-> $stable(sel) [*4])
		else $error("select changed during strobe");
	AST_DONE_PULSE: assert property (lpc_done |=> !lpc_done)
		else $error("done longer than one cycle");
	AST_GRANT_CAUSE: assert property ($rose(lpc_gnt) |-> $past(lpc_req))
		else $error("grant without request");
	AST_ABORT_ALONE: assert property (lpc_abort |-> !lpc_done)
		else $error("abort and done together");
endmodule // sxb_bridge_chk
bind sxb_bridge sxb_bridge_chk chk_u (.pclk(pclk), .presetn(presetn), .smb_clk_oe(smb_clk_oe), .lpc_req(lpc_req),
	.lpc_gnt(lpc_gnt), .lpc_done(lpc_done), .lpc_abort(lpc_abort), .chip_sel_zero_n(chip_sel_zero_n),
	.chip_sel_one_hi(chip_sel_one_hi), .chip_sel_two_n(chip_sel_two_n), .chip_sel_three_n(chip_sel_three_n),
	.ext_read_strobe_n(ext_read_strobe_n), .ext_write_strobe_n(ext_write_strobe_n), .ext_data_oe(ext_data_oe));
`default_nettype wire

// >>> sxb_periph.sv
`default_nettype none
// ============================================================
// External 8-bit peripheral on the select and strobe bus.
module sxb_periph #(
	parameter logic [7:0] RD_VAL = 8'hc3
) (
	input wire logic pclk,
	input wire logic sel_any,
	input wire logic oe,
	output logic [7:0] ext_data_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] junk_ff = 8'h55;
	// An undriven bus shows a changing pattern so a stale byte never looks valid.
	always @(posedge pclk) junk_ff <= ~junk_ff;
	assign ext_data_in = (sel_any && !oe) ? RD_VAL : junk_ff;
endmodule // sxb_periph
`default_nettype wire

// >>> sxb_bridge_tb_top.sv
`default_nettype none
`include "sxb_consts.vh"
module sxb_bridge_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// ============================================================
	// Signals
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, errv, ja;
	logic tb_scl = 1, tb_sda = 1, lpc_req = 0, lpc_cyc = 0, lpc_write = 0, mclr = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, rdv;
	logic [15:0] lpc_addr = 0;
	logic [7:0] lpc_wdata = 0, xd_seen = 0, rb;
	logic [3:0] sel_seen = 0, xa_seen = 0, nk;
	wire pready, pslverr, scl_oe, sda_oe, lpc_gnt, lpc_done, cs0_n, cs1, cs2_n, cs3_n, rd_n, wr_n, xoe;
	wire [31:0] prdata;
	wire [7:0] lpc_rdata, xdo, xdi;
	wire [3:0] xa;
	wire scl_w = tb_scl & ~scl_oe;
	wire sda_w = tb_sda & ~sda_oe;
	int miscompares = 0, check_count = 0;
	logic [19:0] dec_tab [6] = '{20'h00801, 20'h10800, 20'h00810, 20'h03012, 20'h04134, 20'h041c0};
	always #20 pclk = ~pclk;
	sxb_bridge #(.TOUT_CYC(200)) dut_u (
		.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .smb_clk_in(scl_w),
		.smb_clk_out(), .smb_clk_oe(scl_oe), .smb_data_in(sda_w), .smb_data_out(), .smb_data_oe(sda_oe),
		.lpc_req(lpc_req), .lpc_gnt(lpc_gnt), .lpc_cyc(lpc_cyc), .lpc_addr(lpc_addr), .lpc_write(lpc_write),
		.lpc_wdata(lpc_wdata), .lpc_rdata(lpc_rdata), .lpc_done(lpc_done), .lpc_abort(),
		.chip_sel_zero_n(cs0_n), .chip_sel_one_hi(cs1), .chip_sel_two_n(cs2_n), .chip_sel_three_n(cs3_n),
		.ext_read_strobe_n(rd_n), .ext_write_strobe_n(wr_n), .ext_addr_bus(xa), .ext_data_in(xdi),
		.ext_data_out(xdo), .ext_data_oe(xoe));
	sxb_periph per_u (.pclk(pclk), .sel_any(!cs0_n || cs1 || !cs2_n || !cs3_n), .oe(xoe), .ext_data_in(xdi));
	// Records which selects, address and write byte each external cycle showed.
	always @(posedge pclk) begin
		if (lpc_cyc || mclr)
			sel_seen <= 4'h0;
		else
			sel_seen <= sel_seen | {~cs3_n, ~cs2_n, cs1, ~cs0_n};
		if (!rd_n || !wr_n)
			xa_seen <= xa;
		if (!wr_n)
			xd_seen <= xdo;
	end
	// ============================================================
	// Tasks
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task conclude;
		$display("comparisons %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task apb(input logic w, input logic [9:0] idx, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rdv = prdata;
		errv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rdck(input logic [9:0] idx, input logic [7:0] exp);
		apb(1'b0, idx, 8'h00);
		chk(rdv, {24'h0, exp});
	endtask
	task lpc(input logic w, input logic [15:0] a, input logic [7:0] d);
		@(posedge pclk);
		lpc_cyc <= 1'b1;
		lpc_addr <= a;
		lpc_write <= w;
		lpc_wdata <= d;
		@(posedge pclk);
		lpc_cyc <= 1'b0;
		do @(posedge pclk); while (lpc_done !== 1'b1);
	endtask
	// Start is scond(1, 0) and leaves the clock low; stop is scond(0, 1).
	task scond(input logic a, input logic b);
		mclr <= ~b;
		repeat (2) @(posedge pclk);
		mclr <= 1'b0;
		tb_sda <= a;
		repeat (2) @(posedge pclk);
		tb_scl <= 1'b1;
		repeat (4) @(posedge pclk);
		tb_sda <= b;
		repeat (4) @(posedge pclk);
		tb_scl <= b;
	endtask
	task sbit(input logic b, output logic r);
		repeat (2) @(posedge pclk);
		tb_sda <= b;
		repeat (2) @(posedge pclk);
		tb_scl <= 1'b1;
		do @(posedge pclk); while (scl_w !== 1'b1);
		repeat (3) @(posedge pclk);
		r = sda_w;
		tb_scl <= 1'b0;
	endtask
	task sbyte(input logic [7:0] v, input logic m, output logic [7:0] r, output logic a);
		for (int i = 7; i >= 0; i--)
			sbit(v[i], r[i]);
		sbit(m, a);
	endtask
	task swr(input logic [7:0] a, input logic [7:0] c, input logic [7:0] d);
		scond(1'b1, 1'b0);
		sbyte(a, 1'b1, rb, nk[2]);
		sbyte(c, 1'b1, rb, nk[1]);
		sbyte(d, 1'b1, rb, nk[0]);
		scond(1'b0, 1'b1);
	endtask
	task srd(input logic [7:0] c);
		scond(1'b1, 1'b0);
		sbyte(8'h58, 1'b1, rb, nk[3]);
		sbyte(c, 1'b1, rb, nk[2]);
		scond(1'b1, 1'b0);
		sbyte(8'h59, 1'b1, rb, nk[1]);
		sbyte(8'hff, 1'b1, rb, nk[0]);
		scond(1'b0, 1'b1);
	endtask
	// ============================================================
	// Tests
	// The run needs well under 30000 cycles, so 2 ms only trips on a hang.
	initial begin
		#2000000;
		miscompares++;
		conclude;
	end
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		rdck(`SXB_IDX_CS0_A, 8'h00);
		rdck(`SXB_IDX_MODE, 8'h00);
		rdck(`SXB_IDX_SADDR, 8'h2c);
		apb(1'b1, 10'h3ff, 8'h11);
		chk({rdv[30:0], errv}, 32'h1);
		$display("test registers done");
		apb(1'b1, `SXB_IDX_OSC, 8'h40);
		apb(1'b1, `SXB_IDX_CS0_B, 8'h80);
		apb(1'b1, `SXB_IDX_CS1_A, 8'h03);
		apb(1'b1, `SXB_IDX_CS2_A, 8'h04);
		apb(1'b1, `SXB_IDX_CS2_B, 8'h10);
		lpc_req <= 1'b1;
		do @(posedge pclk); while (lpc_gnt !== 1'b1);
		foreach (dec_tab[i]) begin
			lpc(1'b0, dec_tab[i][19:4], 8'h00);
			chk(32'(sel_seen), 32'(dec_tab[i][3:0]));
		end
		lpc(1'b0, 16'h0080, 8'h00);
		chk(32'(lpc_rdata), 32'hc3);
		lpc(1'b0, 16'h1080, 8'h00);
		chk(32'(lpc_rdata), 32'hff);
		lpc(1'b1, 16'h0302, 8'h5a);
		chk(32'({sel_seen, xa_seen, xd_seen}), 32'h225a);
		apb(1'b1, `SXB_IDX_MODE, 8'h01);
		lpc(1'b0, 16'h041c, 8'h00);
		chk(32'({sel_seen, xa_seen}), 32'h4c);
		$display("test lpc decode done");
		apb(1'b1, `SXB_IDX_CS1_B, 8'h01);
		lpc(1'b0, 16'h0300, 8'h00);
		chk(32'(sel_seen), 32'h0);
		apb(1'b1, `SXB_IDX_CS1_B, 8'h02);
		apb(1'b1, `SXB_IDX_CS1_B, 8'h00);
		rdck(`SXB_IDX_CS1_B, 8'h02);
		apb(1'b1, `SXB_IDX_CS2_A, 8'h07);
		rdck(`SXB_IDX_CS2_A, 8'h04);
		apb(1'b1, `SXB_IDX_CS0_B, 8'h90);
		rdck(`SXB_IDX_CS0_B, 8'h90);
		lpc(1'b0, 16'h0090, 8'h00);
		chk(32'(sel_seen), 32'h1);
		$display("test protect done");
		lpc_req <= 1'b0;
		repeat (4) @(posedge pclk);
		swr(8'h58, 8'h02, 8'h01);
		chk(32'(nk[2:0]), 32'h0);
		srd(8'h02);
		chk(32'({nk, rb}), 32'h103);
		lpc_req <= 1'b1;
		repeat (8) @(posedge pclk);
		chk(32'(lpc_gnt), 32'h0);
		swr(8'h58, 8'h85, 8'ha7);
		repeat (12) @(posedge pclk);
		chk(32'({sel_seen, xa_seen, xd_seen}), 32'h15a7);
		srd(8'h93);
		chk(32'({sel_seen, rb}), 32'h2c3);
		srd(8'h40);
		chk(32'({nk, rb}), 32'h100);
		swr(8'h5a, 8'h85, 8'h01);
		chk(32'(nk[2:0]), 32'h7);
		scond(1'b1, 1'b0);
		sbyte(8'h59, 1'b1, rb, ja);
		scond(1'b0, 1'b1);
		chk(32'(ja), 32'h1);
		scond(1'b1, 1'b0);
		sbyte(8'h58, 1'b1, rb, ja);
		sbyte(8'h85, 1'b1, rb, ja);
		sbyte(8'h01, 1'b1, rb, ja);
		sbyte(8'h02, 1'b1, rb, ja);
		scond(1'b0, 1'b1);
		repeat (12) @(posedge pclk);
		chk(32'({sel_seen, ja}), 32'h1);
		scond(1'b1, 1'b0);
		sbyte(8'h58, 1'b1, rb, ja);
		sbyte(8'h85, 1'b1, rb, ja);
		scond(1'b0, 1'b1);
		repeat (12) @(posedge pclk);
		chk(32'({sel_seen, ja}), 32'h0);
		scond(1'b1, 1'b0);
		sbyte(8'h58, 1'b1, rb, ja);
		repeat (220) @(posedge pclk);
		sbyte(8'h85, 1'b1, rb, ja);
		scond(1'b0, 1'b1);
		chk(32'(ja), 32'h1);
		scond(1'b1, 1'b0);
		scond(1'b0, 1'b1);
		rdck(`SXB_IDX_STATUS, 8'h12);
		swr(8'h58, 8'h02, 8'h00);
		do @(posedge pclk); while (lpc_gnt !== 1'b1);
		swr(8'h58, 8'h02, 8'h08);
		repeat (8) @(posedge pclk);
		chk(32'({lpc_gnt, nk[2:0]}), 32'h0);
		swr(8'h58, 8'h02, 8'h00);
		do @(posedge pclk); while (lpc_gnt !== 1'b1);
		$display("test smbus done");
		conclude;
	end
endmodule // sxb_bridge_tb_top
`default_nettype wire
